// ### rbi_pkg.sv
package rbi_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_PROCESSOR_MODE_STATUS_REG    = 4'h0;
  localparam logic [3:0] ADDR_IMR     = 4'h1;
  localparam logic [3:0] ADDR_IFR     = 4'h2;
  localparam logic [3:0] ADDR_ICR     = 4'h3;
  localparam logic [3:0] ADDR_CTRL    = 4'h4;
  localparam logic [3:0] ADDR_STAT    = 4'h5;
  localparam logic [3:0] ADDR_IRQMASK = 4'h6;
  localparam logic [3:0] ADDR_PC      = 4'h7;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FLAG_NMI   = 0;
  localparam int FLAG_IRQ1  = 1;
  localparam int FLAG_IRQ2  = 2;
  localparam int FLAG_IRQ3  = 3;
  localparam int EV_TRAP    = 0;
  localparam int EV_RUN     = 1;
  localparam int EV_BRANCH  = 2;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [4:0]  BOOT_CYCLES   = 5'h10;
  localparam logic [15:0] VEC_NMI       = 16'h0024;
  localparam logic [15:0] VEC_IRQ1      = 16'h0002;
  localparam logic [15:0] VEC_IRQ2      = 16'h0004;
  localparam logic [15:0] VEC_IRQ3      = 16'h0006;
  localparam logic [3:0]  MCYC_HALF     = 4'h1;
  localparam logic [15:0] ZERO16        = 16'h0000;

  typedef enum logic [2:0] {
    RBI_HALT = 3'b001,
    RBI_BOOT = 3'b010,
    RBI_RUN  = 3'b100
  } rbi_state_e;
endpackage : rbi_pkg

// ### rbi_core.sv
// Contract
// - reset halts execution, program counter held zero
// - after release wait 16 cycles, start zero
// - map select low flash, high external
// - map select latched only at reset, bit0
// - nmi traps regardless of any mask
// - hold/irq1 pin always an interrupt source
// - reset clears control mode bit to zero
// - irq2 over irq3, individual and global masks
// - irq2/irq3 flags readable and software clearable
// - branch instruction taken when branch pin low
// - machine clock toggles, cycle rising to rising
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module rbi_core #(
  parameter int MCYC_DIV = 2
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        reset_input_n,
  input  wire logic        memory_map_select,
  input  wire logic        nonmaskable_irq_n,
  input  wire logic        hold_or_irq1_pin_n,
  input  wire logic        user_irq2_n,
  input  wire logic        user_irq3_n,
  input  wire logic        branch_condition_pin,
  input  wire logic        branch_if_low_instr,
  input  wire logic        irq_ack,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  output logic [15:0]      rdata,
  output logic             machine_clock_out,
  output logic             cpu_running,
  output logic [15:0]      program_counter,
  output logic             flash_mapped,
  output logic             trap_valid,
  output logic [15:0]      trap_vector,
  output logic             branch_taken,
  output logic             irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        rs_sync;
    logic [2:0]        nmi_sync;
    logic [2:0]        i1_sync;
    logic [2:0]        i2_sync;
    logic [2:0]        i3_sync;
    logic [2:0]        bio_sync;
    logic [2:0]        mp_sync;
    logic              rs_lvl;
    logic              nmi_lvl;
    logic              i1_lvl;
    logic              i2_lvl;
    logic              i3_lvl;
    logic              bio_lvl;
    rbi_pkg::rbi_state_e st;
    logic [4:0]        boot_cnt;
    logic [3:0]        div_cnt;
    logic              mclk_out;
    logic              mcyc_tick;
    logic [15:0]       pc;
    logic              pmst0;
    logic [3:0]        irq_mask_reg;
    logic [3:0]        irq_flag_reg;
    logic              icr_mode;
    logic              global_irq_mask_bit;
    logic              trap_v;
    logic [15:0]       trap_vec;
    logic              br_taken;
    logic [2:0]        ev_stat;
    logic [2:0]        ev_mask;
    logic              irq_o;
    logic              run_o;
    logic              fmap_o;
    logic [15:0]       rdata;
  } rbi_core_s;

  rbi_core_s r_reg;
  rbi_core_s r_next;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       wr_processor_mode_status_reg;
    logic [3:0] pend;
    logic [2:0] ev;
    r_next  = r_reg;
    wr_processor_mode_status_reg = 1'b0;
    pend    = 4'h0;
    ev      = 3'h0;

    // three stages, change counts once stages two and three agree
    r_next.rs_sync  = {r_reg.rs_sync[1:0],  reset_input_n};
    r_next.nmi_sync = {r_reg.nmi_sync[1:0], nonmaskable_irq_n};
    r_next.i1_sync  = {r_reg.i1_sync[1:0],  hold_or_irq1_pin_n};
    r_next.i2_sync  = {r_reg.i2_sync[1:0],  user_irq2_n};
    r_next.i3_sync  = {r_reg.i3_sync[1:0],  user_irq3_n};
    r_next.bio_sync = {r_reg.bio_sync[1:0], branch_condition_pin};
    r_next.mp_sync  = {r_reg.mp_sync[1:0],  memory_map_select};
    if (r_reg.rs_sync[1] == r_reg.rs_sync[2])   r_next.rs_lvl  = r_reg.rs_sync[2];
    if (r_reg.nmi_sync[1] == r_reg.nmi_sync[2]) r_next.nmi_lvl = r_reg.nmi_sync[2];
    if (r_reg.i1_sync[1] == r_reg.i1_sync[2])   r_next.i1_lvl  = r_reg.i1_sync[2];
    if (r_reg.i2_sync[1] == r_reg.i2_sync[2])   r_next.i2_lvl  = r_reg.i2_sync[2];
    if (r_reg.i3_sync[1] == r_reg.i3_sync[2])   r_next.i3_lvl  = r_reg.i3_sync[2];
    if (r_reg.bio_sync[1] == r_reg.bio_sync[2]) r_next.bio_lvl = r_reg.bio_sync[2];

    // machine clock: high half then low half, tick at each rising edge
    r_next.mcyc_tick = 1'b0;
    if (r_reg.div_cnt == 4'(MCYC_DIV / 2 - 1)) begin
      r_next.div_cnt  = 4'h0;
      r_next.mclk_out = ~r_reg.mclk_out;
      r_next.mcyc_tick = ~r_reg.mclk_out;
    end else begin
      r_next.div_cnt = r_reg.div_cnt + 4'h1;
    end

    // one-cycle pulses fall back unless the sequencer raises them
    r_next.trap_v   = 1'b0;
    r_next.br_taken = 1'b0;

    // registers
    if (wr_strobe) begin
      case (addr)
        rbi_pkg::ADDR_IMR:     r_next.irq_mask_reg      = wdata[3:0];
        rbi_pkg::ADDR_IFR:     r_next.irq_flag_reg      = r_reg.irq_flag_reg & ~wdata[3:0];
        rbi_pkg::ADDR_ICR:     r_next.icr_mode = wdata[0];
        rbi_pkg::ADDR_CTRL:    r_next.global_irq_mask_bit     = wdata[0];
        rbi_pkg::ADDR_STAT:    r_next.ev_stat  = r_reg.ev_stat & ~wdata[2:0];
        rbi_pkg::ADDR_IRQMASK: r_next.ev_mask  = wdata[2:0];
        default:               wr_processor_mode_status_reg         = 1'b0;
      endcase
    end
    r_next.rdata = rbi_pkg::ZERO16;
    if (rd_strobe) begin
      case (addr)
        rbi_pkg::ADDR_PROCESSOR_MODE_STATUS_REG:    r_next.rdata = {15'h0000, r_reg.pmst0};
        rbi_pkg::ADDR_IMR:     r_next.rdata = {12'h000, r_reg.irq_mask_reg};
        rbi_pkg::ADDR_IFR:     r_next.rdata = {12'h000, r_reg.irq_flag_reg};
        rbi_pkg::ADDR_ICR:     r_next.rdata = {15'h0000, r_reg.icr_mode};
        rbi_pkg::ADDR_CTRL:    r_next.rdata = {15'h0000, r_reg.global_irq_mask_bit};
        rbi_pkg::ADDR_STAT:    r_next.rdata = {13'h0000, r_reg.ev_stat};
        rbi_pkg::ADDR_IRQMASK: r_next.rdata = {13'h0000, r_reg.ev_mask};
        rbi_pkg::ADDR_PC:      r_next.rdata = r_reg.pc;
        default:               r_next.rdata = rbi_pkg::ZERO16;
      endcase
    end

    // hardware sets after the clear so a same-cycle event survives
    if (r_reg.nmi_lvl && !r_next.nmi_lvl) r_next.irq_flag_reg[rbi_pkg::FLAG_NMI]  = 1'b1;
    if (r_reg.i1_lvl && !r_next.i1_lvl)   r_next.irq_flag_reg[rbi_pkg::FLAG_IRQ1] = 1'b1;
    if (r_reg.i2_lvl && !r_next.i2_lvl)   r_next.irq_flag_reg[rbi_pkg::FLAG_IRQ2] = 1'b1;
    if (r_reg.i3_lvl && !r_next.i3_lvl)   r_next.irq_flag_reg[rbi_pkg::FLAG_IRQ3] = 1'b1;

    // sequencer
    case (r_reg.st)
      rbi_pkg::RBI_HALT: begin
        r_next.pc       = rbi_pkg::PC_RESET;
        r_next.icr_mode = 1'b0;
        r_next.pmst0    = r_reg.mp_sync[2];
        r_next.boot_cnt = 5'h00;
        if (r_reg.rs_lvl) begin
          r_next.st = rbi_pkg::RBI_BOOT;
        end
      end
      rbi_pkg::RBI_BOOT: begin
        r_next.pc = rbi_pkg::PC_RESET;
        if (r_reg.mcyc_tick) begin
          r_next.boot_cnt = r_reg.boot_cnt + 5'h01;
          if (r_reg.boot_cnt == rbi_pkg::BOOT_CYCLES - 5'h01) begin
            r_next.st = rbi_pkg::RBI_RUN;
            ev[rbi_pkg::EV_RUN] = 1'b1;
          end
        end
      end
      rbi_pkg::RBI_RUN: begin
        if (r_reg.mcyc_tick) begin
          pend = r_reg.irq_flag_reg & {~r_reg.global_irq_mask_bit, ~r_reg.global_irq_mask_bit, ~r_reg.global_irq_mask_bit, 1'b1}
                 & {r_reg.irq_mask_reg[3:1], 1'b1};
          if (pend[rbi_pkg::FLAG_NMI]) begin
            r_next.trap_vec = rbi_pkg::VEC_NMI;
            r_next.irq_flag_reg[rbi_pkg::FLAG_NMI] = 1'b0;
          end else if (pend[rbi_pkg::FLAG_IRQ1]) begin
            r_next.trap_vec = rbi_pkg::VEC_IRQ1;
            r_next.irq_flag_reg[rbi_pkg::FLAG_IRQ1] = 1'b0;
          end else if (pend[rbi_pkg::FLAG_IRQ2]) begin
            r_next.trap_vec = rbi_pkg::VEC_IRQ2;
            r_next.irq_flag_reg[rbi_pkg::FLAG_IRQ2] = 1'b0;
          end else if (pend[rbi_pkg::FLAG_IRQ3]) begin
            r_next.trap_vec = rbi_pkg::VEC_IRQ3;
            r_next.irq_flag_reg[rbi_pkg::FLAG_IRQ3] = 1'b0;
          end
          if (pend != 4'h0) begin
            r_next.trap_v = 1'b1;
            r_next.pc     = r_next.trap_vec;
            r_next.global_irq_mask_bit   = 1'b1;
            ev[rbi_pkg::EV_TRAP] = 1'b1;
          end else if (branch_if_low_instr && !r_reg.bio_lvl) begin
            r_next.br_taken = 1'b1;
            r_next.pc       = wdata;
            ev[rbi_pkg::EV_BRANCH] = 1'b1;
          end else begin
            r_next.pc = r_reg.pc + 16'h0001;
          end
        end
      end
      default: r_next.st = rbi_pkg::RBI_HALT;
    endcase
    if (irq_ack) begin
      r_next.global_irq_mask_bit = 1'b0;
    end
    if (!r_reg.rs_lvl) begin
      r_next.st = rbi_pkg::RBI_HALT;
    end
    r_next.ev_stat = r_next.ev_stat | ev;
    r_next.irq_o   = |(r_next.ev_stat & r_next.ev_mask);
    if (wr_processor_mode_status_reg) begin
      r_next.pmst0 = r_reg.pmst0;
    end
    // outputs from flops, built from next state so no cycle is lost
    r_next.run_o  = r_next.st == rbi_pkg::RBI_RUN;
    r_next.fmap_o = ~r_next.pmst0;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      r_reg          <= '0;
      r_reg.rs_sync  <= 3'h0;
      r_reg.nmi_sync <= 3'h7;
      r_reg.i1_sync  <= 3'h7;
      r_reg.i2_sync  <= 3'h7;
      r_reg.i3_sync  <= 3'h7;
      r_reg.bio_sync <= 3'h7;
      r_reg.nmi_lvl  <= 1'b1;
      r_reg.i1_lvl   <= 1'b1;
      r_reg.i2_lvl   <= 1'b1;
      r_reg.i3_lvl   <= 1'b1;
      r_reg.bio_lvl  <= 1'b1;
      r_reg.global_irq_mask_bit     <= 1'b1;
      r_reg.st       <= rbi_pkg::RBI_HALT;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata             = r_reg.rdata;
  assign machine_clock_out = r_reg.mclk_out;
  assign cpu_running       = r_reg.run_o;
  assign program_counter   = r_reg.pc;
  assign flash_mapped      = r_reg.fmap_o;
  assign trap_valid        = r_reg.trap_v;
  assign trap_vector       = r_reg.trap_vec;
  assign branch_taken      = r_reg.br_taken;
  assign irq               = r_reg.irq_o;
endmodule : rbi_core
`default_nettype wire

// ### rbi_core_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rbi_core_chk #(
  parameter int MCYC_DIV = 2
) (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        reset_input_n,
  input wire logic        memory_map_select,
  input wire logic        nonmaskable_irq_n,
  input wire logic        branch_condition_pin,
  input wire logic        branch_if_low_instr,
  input wire logic        machine_clock_out,
  input wire logic        cpu_running,
  input wire logic [15:0] program_counter,
  input wire logic        flash_mapped,
  input wire logic        trap_valid,
  input wire logic [15:0] trap_vector,
  input wire logic        branch_taken
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic       mco_q;
  logic [7:0] mc_cnt;
  // zero until the first rise, so a partial first period is not judged
  always_ff @(posedge mclk) begin
    mco_q <= machine_clock_out;
    if (reset) mc_cnt <= 8'h00;
    else if (machine_clock_out && !mco_q) mc_cnt <= 8'h01;
    else if (mc_cnt != 8'h00) mc_cnt <= mc_cnt + 8'h01;
  end
  property p_halt; (!reset_input_n)[*8] |-> !cpu_running && program_counter == 16'h0000; endproperty
  a_halt: assert property (p_halt) else $error("pc not held in halt");
  property p_boot_wait; $rose(cpu_running) |-> $past(reset_input_n, 32) && program_counter == 16'h0000; endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("run started early");
  property p_boot_bound; $rose(reset_input_n) |-> ##[33:60] cpu_running; endproperty
  a_boot_bound: assert property (p_boot_bound) else $error("run never started");
  property p_map_latch; (!reset_input_n && $stable(memory_map_select))[*8] |-> flash_mapped != memory_map_select; endproperty
  a_map_latch: assert property (p_map_latch) else $error("map select not latched");
  property p_map_stable; cpu_running |-> $stable(flash_mapped); endproperty
  a_map_stable: assert property (p_map_stable) else $error("map moved while running");
  property p_nmi; $fell(nonmaskable_irq_n) && cpu_running |-> ##[1:10] (trap_valid && trap_vector == rbi_pkg::VEC_NMI); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not trapped");
  property p_branch; branch_taken |-> !$past(branch_condition_pin, 4) && ($past(branch_if_low_instr) || $past(branch_if_low_instr, 2)); endproperty
  a_branch: assert property (p_branch) else $error("branch without cause");
  property p_mco; (machine_clock_out && !mco_q && mc_cnt != 8'h00) |-> mc_cnt == MCYC_DIV; endproperty
  a_mco: assert property (p_mco) else $error("machine clock period wrong");
endmodule : rbi_core_chk
bind rbi_core rbi_core_chk #(.MCYC_DIV(MCYC_DIV)) u_chk (.mclk, .reset, .reset_input_n,
  .memory_map_select, .nonmaskable_irq_n, .branch_condition_pin, .branch_if_low_instr,
  .machine_clock_out, .cpu_running, .program_counter, .flash_mapped, .trap_valid,
  .trap_vector, .branch_taken);
`default_nettype wire

// ### rbi_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module rbi_pin_model (
  output logic       rst_n,
  output logic       map_sel,
  output logic       br_pin,
  output logic [3:0] irq_n,
  input  wire logic  mclk
);
  // lines rest high as if pulled up; reset held from power-up
  initial begin
    rst_n = 1'b0;
    map_sel = 1'b1;
    br_pin = 1'b1;
    irq_n = 4'hf;
  end
  task automatic drive(input logic r, m, b);
    @(posedge mclk);
    rst_n <= r;
    map_sel <= m;
    br_pin <= b;
  endtask : drive
  // low longer than the sync chain, so no edge is lost
  task automatic pulse(input logic [3:0] m);
    @(posedge mclk);
    irq_n <= ~m;
    repeat (4) @(posedge mclk);
    irq_n <= 4'hf;
  endtask : pulse
endmodule : rbi_pin_model
`default_nettype wire

// ### rbi_core_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rbi_core_tb_top;
  logic        mclk, reset, rn, msel, bp, bi, ack, wr, rd, mco, run, fm, tv, bt, irq, a;
  logic [3:0]  irqn, addr;
  logic [15:0] wdata, rdata, pc, tvec;
  logic [15:0] traps[$];
  int          err_total, tests_run, cyc, n, nbr;
  rbi_pin_model pm (.rst_n(rn), .map_sel(msel), .br_pin(bp), .irq_n(irqn), .mclk);
  rbi_core dut (.mclk, .reset, .reset_input_n(rn), .memory_map_select(msel),
    .nonmaskable_irq_n(irqn[0]), .hold_or_irq1_pin_n(irqn[1]), .user_irq2_n(irqn[2]),
    .user_irq3_n(irqn[3]), .branch_condition_pin(bp), .branch_if_low_instr(bi),
    .irq_ack(ack), .addr, .wdata, .wr_strobe(wr), .rd_strobe(rd), .rdata,
    .machine_clock_out(mco), .cpu_running(run), .program_counter(pc), .flash_mapped(fm),
    .trap_valid(tv), .trap_vector(tvec), .branch_taken(bt), .irq);
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] ad, input logic [15:0] v);
    @(posedge mclk);
    {addr, wdata, wr} <= {ad, v, 1'b1};
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] ad, input logic [15:0] e);
    @(posedge mclk);
    {addr, rd} <= {ad, 1'b1};
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk
  task automatic trap_chk(input logic [15:0] e);
    repeat (20) if (traps.size() == 0) @(posedge mclk);
    chk(traps.size() == 0 ? 16'hffff : traps.pop_front(), e);
  endtask : trap_chk
  task automatic pls(input logic [1:0] m, input int k);
    @(posedge mclk);
    {ack, bi} <= m;
    repeat (k) @(posedge mclk);
    {ack, bi} <= 2'b00;
  endtask : pls
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // traps and branches are one-cycle pulses, so catch every one
  always @(posedge mclk) begin
    cyc++;
    if (tv === 1'b1) traps.push_back(tvec);
    if (bt === 1'b1) nbr++;
    if (cyc == 6000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    reset = 1'b1;
    {bi, ack, wr, rd, addr, wdata} = '0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({run, fm, pc[13:0]}, 16'h0000);
    rd_chk(rbi_pkg::ADDR_PROCESSOR_MODE_STATUS_REG, 16'h0001);
    rd_chk(rbi_pkg::ADDR_ICR, 16'h0000);
    pm.drive(1'b1, 1'b1, 1'b1);
    n = 0;
    while (run !== 1'b1 && n < 99) begin
      @(negedge mclk);
      n++;
    end
    chk(16'(n > 32 && n < 60), 16'h0001);
    pm.drive(1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge mclk);
    rd_chk(rbi_pkg::ADDR_PROCESSOR_MODE_STATUS_REG, 16'h0001);
    chk({15'h0, fm}, 16'h0000);
    pm.pulse(4'hc);
    repeat (6) @(posedge mclk);
    rd_chk(rbi_pkg::ADDR_IFR, 16'h000c);
    chk(16'(traps.size()), 16'h0000);
    pm.pulse(4'h1);
    trap_chk(rbi_pkg::VEC_NMI);
    wr_reg(rbi_pkg::ADDR_IFR, 16'h000f);
    rd_chk(rbi_pkg::ADDR_IFR, 16'h0000);
    wr_reg(rbi_pkg::ADDR_IMR, 16'h000e);
    wr_reg(rbi_pkg::ADDR_CTRL, 16'h0000);
    pm.pulse(4'hc);
    trap_chk(rbi_pkg::VEC_IRQ2);
    pls(2'b10, 1);
    trap_chk(rbi_pkg::VEC_IRQ3);
    pls(2'b10, 1);
    pm.pulse(4'h2);
    trap_chk(rbi_pkg::VEC_IRQ1);
    pls(2'b10, 1);
    wr_reg(rbi_pkg::ADDR_IMR, 16'h0008);
    pm.pulse(4'h4);
    repeat (8) @(posedge mclk);
    chk(16'(traps.size()), 16'h0000);
    pm.drive(1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge mclk);
    pls(2'b01, 2);
    pm.drive(1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge mclk);
    pls(2'b01, 2);
    repeat (6) @(posedge mclk);
    chk(16'(nbr), 16'h0001);
    rd_chk(rbi_pkg::ADDR_STAT, 16'h0007);
    wr_reg(rbi_pkg::ADDR_IRQMASK, 16'h0007);
    repeat (2) @(posedge mclk);
    a = irq;
    wr_reg(rbi_pkg::ADDR_IRQMASK, 16'h0000);
    repeat (2) @(posedge mclk);
    chk({15'h0, a ^ irq}, 16'h0001);
    wr_reg(rbi_pkg::ADDR_STAT, 16'h0007);
    rd_chk(rbi_pkg::ADDR_STAT, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    pm.drive(1'b0, 1'b0, 1'b1);
    repeat (10) @(posedge mclk);
    chk({run, pc[14:0]}, 16'h0000);
    rd_chk(rbi_pkg::ADDR_PROCESSOR_MODE_STATUS_REG, 16'h0000);
    complete_run();
  end
endmodule : rbi_core_tb_top
`default_nettype wire
